// ==== vcr_top.sv ====
// Comparator control register bank: configuration, power-down key, status and interrupts
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module vcr_top (
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Analog side
  input wire logic compare_result_raw,
  input wire logic ref_above_supply,
  output logic [3:0] ref_level_code,
  output logic [1:0] ref_input_select,
  output logic [1:0] mon_input_select,
  output logic ref_clamp_to_supply,
  output logic bandgap_enable,
  output logic result_settled,
  output logic comparator_power_down,
  // Interrupt
  output logic irq
);
  import vcr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic compare_result;
  logic supply_over;
  logic result_prev;
  logic [3:0] level_q;
  logic [1:0] ref_sel_q;
  logic [1:0] mon_sel_q;
  logic [31:0] key_q;
  logic powered_down_flag;
  logic [1:0] irq_en;
  logic [1:0] irq_stat;
  logic [1:0] next_irq_stat;
  logic [1:0] hw_set;
  logic [1:0] en_rise_edge;
  logic temp_sel_start;
  logic settled;
  logic [31:0] next_rdata;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic wr_hit(input logic w, input logic [11:0] a, input logic [11:0] ofs);
    wr_hit = w && hit(a, ofs);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronise the analog inputs before any logic looks at them
  vcr_sync u_sync_result (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(compare_result_raw),
    .sync_out(compare_result)
  );

  vcr_sync u_sync_over (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(ref_above_supply),
    .sync_out(supply_over)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration register; reserved bits are simply not stored
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= VCR_CONFIG_RESET[VCR_LEVEL_LSB +: 4];
      ref_sel_q <= VCR_CONFIG_RESET[VCR_REF_SEL_LSB +: 2];
      mon_sel_q <= VCR_CONFIG_RESET[VCR_MON_SEL_LSB +: 2];
    end else if (wr_hit(reg_write, reg_addr, VCR_OFS_CONFIG)) begin
      level_q <= reg_wdata[VCR_LEVEL_LSB +: 4]; // RL1
      ref_sel_q <= reg_wdata[VCR_REF_SEL_LSB +: 2]; // RL3
      mon_sel_q <= reg_wdata[VCR_MON_SEL_LSB +: 2]; // RL4 RL6
    end
  end

  // Temperature selection start pulse restarts the settling timer
  assign temp_sel_start = wr_hit(reg_write, reg_addr, VCR_OFS_CONFIG)
    && (reg_wdata[VCR_MON_SEL_LSB +: 2] == VCR_MON_TEMP)
    && (mon_sel_q != VCR_MON_TEMP);

  vcr_settle u_settle (
    .clock(clock),
    .reset_n(reset_n),
    .start(temp_sel_start),
    .active(mon_sel_q == VCR_MON_TEMP),
    .settled(settled)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Analog control outputs, all registered
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ref_level_code <= 4'h0;
      ref_input_select <= 2'h0;
      mon_input_select <= 2'h0;
      ref_clamp_to_supply <= 1'b0;
      bandgap_enable <= 1'b0;
      result_settled <= 1'b1;
      comparator_power_down <= 1'b0;
    end else begin
      ref_level_code <= level_q; // RL1
      ref_input_select <= ref_sel_q; // RL3
      mon_input_select <= mon_sel_q; // RL4
      // Clamp matters only while the internal converter is the reference
      ref_clamp_to_supply <= (ref_sel_q == VCR_REF_DAC) && supply_over; // RL2
      bandgap_enable <= (mon_sel_q == VCR_MON_TEMP); // RL5
      result_settled <= (mon_sel_q != VCR_MON_TEMP) || settled; // RL5
      comparator_power_down <= powered_down_flag; // RL17
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shutdown key; once the key lands the comparator stays off until reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      key_q <= VCR_KEY_RESET; // RL9
      powered_down_flag <= 1'b0; // RL7 RL17
    end else if (wr_hit(reg_write, reg_addr, VCR_OFS_KEY)) begin
      key_q <= reg_wdata; // RL9
      if (reg_wdata == VCR_SHUTDOWN_KEY) begin
        powered_down_flag <= 1'b1; // RL17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt enable mask
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_en <= VCR_IRQ_RESET; // RL10
    end else if (wr_hit(reg_write, reg_addr, VCR_OFS_IRQ_ENABLE)) begin
      irq_en <= reg_wdata[1:0]; // RL11
    end
  end

  // Previous result for edge detection
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      result_prev <= 1'b0;
    end else begin
      result_prev <= compare_result;
    end
  end

  // Enables going 0 to 1 in this write
  assign en_rise_edge = wr_hit(reg_write, reg_addr, VCR_OFS_IRQ_ENABLE)
    ? (reg_wdata[1:0] & ~irq_en) : 2'b00;

  ////////////////////////////////////////////////////////////////////////////////
  // Hardware event sources
  always_comb begin
    hw_set = 2'b00;
    hw_set[VCR_IRQ_RISE_BIT] = (irq_en[VCR_IRQ_RISE_BIT] && compare_result && !result_prev)
      || (en_rise_edge[VCR_IRQ_RISE_BIT] && compare_result); // RL15
    hw_set[VCR_IRQ_FALL_BIT] = (irq_en[VCR_IRQ_FALL_BIT] && !compare_result && result_prev)
      || (en_rise_edge[VCR_IRQ_FALL_BIT] && !compare_result); // RL16
  end

  // Status: clear first, then any set wins over a clear in the same cycle
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_hit(reg_write, reg_addr, VCR_OFS_IRQ_CLEAR)) begin
      next_irq_stat = next_irq_stat & ~reg_wdata[1:0]; // RL13 RL18
    end
    if (wr_hit(reg_write, reg_addr, VCR_OFS_IRQ_FORCE)) begin
      next_irq_stat = next_irq_stat | reg_wdata[1:0]; // RL14 RL18
    end
    next_irq_stat = next_irq_stat | hw_set;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat <= VCR_IRQ_RESET;
    end else begin
      irq_stat <= next_irq_stat; // RL12
    end
  end

  // Level interrupt from the next state so it tracks status with no extra lag
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_stat & next_irq_en()); // RL19 RL10
    end
  end

  function automatic logic [1:0] next_irq_en();
    next_irq_en = wr_hit(reg_write, reg_addr, VCR_OFS_IRQ_ENABLE) ? reg_wdata[1:0] : irq_en;
  endfunction : next_irq_en

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped and write-only offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      VCR_OFS_CONFIG: begin
        next_rdata[VCR_LEVEL_LSB +: 4] = level_q;
        next_rdata[VCR_REF_SEL_LSB +: 2] = ref_sel_q;
        next_rdata[VCR_MON_SEL_LSB +: 2] = mon_sel_q; // RL6
      end
      VCR_OFS_STATUS: begin
        next_rdata[VCR_STAT_PWD_BIT] = powered_down_flag; // RL7
        next_rdata[VCR_STAT_RESULT_BIT] = compare_result; // RL8
      end
      VCR_OFS_KEY: begin
        next_rdata = key_q; // RL9
      end
      VCR_OFS_IRQ_ENABLE: begin
        next_rdata[1:0] = irq_en; // RL11
      end
      VCR_OFS_IRQ_STATUS: begin
        next_rdata[1:0] = irq_stat; // RL12
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : vcr_top
`default_nettype wire

// ==== vcr_pkg.sv ====
// Package: register map, field layout, reset values and timing for the comparator register bank
//
// Notes on behaviour
// [RL1] Four-bit level code picks one of sixteen internal reference steps, used only with converter
// [RL2] Internal reference above supply is clamped to the supply level
// [RL3] Two-bit reference select: three external references or the internal converter
// [RL4] Two-bit monitor select: supply, temperature sensor, external input zero or one
// [RL5] Temperature selection turns bandgap on; results unsettled until it stabilises
// [RL6] Reserved configuration bits read zero and ignore writes
// [RL7] Power-down status bit reads one while powered down, zero after reset
// [RL8] Result bit reads one when monitored input exceeds reference
// [RL9] Thirty-two-bit key register resets zero; writing 0x37 requests power-down
// [RL10] Per-source enable mask gates the interrupt; enables reset zero
// [RL11] Bit one is rise event, bit zero fall event; upper bits read zero
// [RL12] Status read returns latched events since last clear
// [RL13] Writing one to a clear bit clears that status bit
// [RL14] Writing one to a set bit sets that status bit at once
// [RL15] Rise status sets on enabled rising result, or result high when enabled
// [RL16] Fall status sets on enabled falling result, or result low when enabled
// [RL17] Comparator enabled out of reset, powered off after key written
// [RL18] Writing zero to clear or set bits leaves status unchanged
// [RL19] Interrupt output high while any status bit and its enable are both one
package vcr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [11:0] VCR_OFS_CONFIG = 12'h000;
  localparam logic [11:0] VCR_OFS_STATUS = 12'h004;
  localparam logic [11:0] VCR_OFS_KEY = 12'h008;
  localparam logic [11:0] VCR_OFS_IRQ_ENABLE = 12'h200;
  localparam logic [11:0] VCR_OFS_IRQ_STATUS = 12'h204;
  localparam logic [11:0] VCR_OFS_IRQ_CLEAR = 12'h208;
  localparam logic [11:0] VCR_OFS_IRQ_FORCE = 12'h20c;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int VCR_LEVEL_LSB = 16;
  localparam int VCR_REF_SEL_LSB = 8;
  localparam int VCR_MON_SEL_LSB = 0;
  localparam int VCR_STAT_PWD_BIT = 1;
  localparam int VCR_STAT_RESULT_BIT = 0;
  localparam int VCR_IRQ_RISE_BIT = 1;
  localparam int VCR_IRQ_FALL_BIT = 0;
  localparam logic [31:0] VCR_CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] VCR_KEY_RESET = 32'h0000_0000;
  localparam logic [31:0] VCR_SHUTDOWN_KEY = 32'h0000_0037;
  localparam logic [1:0] VCR_IRQ_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Reference and monitor selections
  typedef enum logic [1:0] {
    VCR_REF_EXT0 = 2'b00,
    VCR_REF_EXT1 = 2'b01,
    VCR_REF_EXT2 = 2'b10,
    VCR_REF_DAC = 2'b11
  } vcr_ref_sel_t;

  typedef enum logic [1:0] {
    VCR_MON_SUPPLY = 2'b00,
    VCR_MON_TEMP = 2'b01,
    VCR_MON_EXT0 = 2'b10,
    VCR_MON_EXT1 = 2'b11
  } vcr_mon_sel_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing: bandgap settling, longest-is-least so round up
  localparam int VCR_CLK_MHZ = 100;
  localparam int VCR_BANDGAP_SETTLE_US = 11;
  localparam int VCR_BANDGAP_CYCLES = VCR_BANDGAP_SETTLE_US * VCR_CLK_MHZ;
  localparam int VCR_SETTLE_W = 11;

endpackage : vcr_pkg

// ==== vcr_sync.sv ====
// Two-stage synchroniser for asynchronous single-bit inputs
`timescale 1ns/1ns
`default_nettype none
module vcr_sync (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;

  // First stage is read only by the second
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : vcr_sync
`default_nettype wire

// ==== vcr_settle.sv ====
// Bandgap settling timer: counts cycles after the temperature input is selected
`timescale 1ns/1ns
`default_nettype none
module vcr_settle (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic start,
  input wire logic active,
  output logic settled
);
  import vcr_pkg::*;

  localparam logic [VCR_SETTLE_W-1:0] SETTLE_LAST = VCR_SETTLE_W'(VCR_BANDGAP_CYCLES - 1);

  logic [VCR_SETTLE_W-1:0] count;

  // Restart on every new selection; settled stays high until deselected
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      settled <= 1'b0;
    end else if (start || !active) begin
      count <= '0;
      settled <= 1'b0;
    end else if (!settled) begin
      if (count == SETTLE_LAST) begin
        settled <= 1'b1; // RL5
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule : vcr_settle
`default_nettype wire

// ==== vcr_top_monitor.sv ====
// Checker on the comparator register bank ports
`timescale 1ns/1ns
`default_nettype none
module vcr_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0] ref_level_code,
  input wire logic [1:0] ref_input_select,
  input wire logic [1:0] mon_input_select,
  input wire logic ref_clamp_to_supply,
  input wire logic bandgap_enable,
  input wire logic result_settled,
  input wire logic comparator_power_down,
  input wire logic irq
);
  import vcr_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Read data and analog-side copies
  property p_config_rsvd;
    reg_read && reg_addr == VCR_OFS_CONFIG |=> (reg_rdata & 32'hfff0_fcfc) == 32'h0;
  endproperty
  a_config_rsvd: assert property (p_config_rsvd) else $error("config reserved bits set");
  property p_irq_rsvd;
    reg_read && reg_addr[11:4] == 8'h20 |=> reg_rdata[31:2] == 30'h0;
  endproperty
  a_irq_rsvd: assert property (p_irq_rsvd) else $error("irq reserved bits set");
  property p_stat_pwd;
    reg_read && reg_addr == VCR_OFS_STATUS |=> reg_rdata[31:1] == {30'h0, comparator_power_down};
  endproperty
  a_stat_pwd: assert property (p_stat_pwd) else $error("status power bit wrong");
  property p_config_copy;
    reg_write && reg_addr == VCR_OFS_CONFIG |-> ##2 {ref_level_code, ref_input_select,
      mon_input_select} == {$past(reg_wdata[19:16], 2), $past(reg_wdata[9:8], 2),
      $past(reg_wdata[1:0], 2)};
  endproperty
  a_config_copy: assert property (p_config_copy) else $error("select copies wrong");
  property p_clamp;
    ref_clamp_to_supply |-> ref_input_select == VCR_REF_DAC;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp without converter");
  property p_bandgap;
    bandgap_enable |-> mon_input_select == VCR_MON_TEMP;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap on wrongly");
  // Short window only; the full settle count is judged by the bench
  property p_settle;
    $rose(bandgap_enable) |-> ##1 !result_settled [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("settled too early");
  ////////////////////////////////////////////////////////////////////////////////
  // Power-down and interrupt mask
  property p_key_off;
    reg_write && reg_addr == VCR_OFS_KEY && reg_wdata == VCR_SHUTDOWN_KEY
      |-> ##[1:2] comparator_power_down;
  endproperty
  a_key_off: assert property (p_key_off) else $error("key did not power down");
  property p_off_sticky;
    comparator_power_down |=> comparator_power_down;
  endproperty
  a_off_sticky: assert property (p_off_sticky) else $error("power-down dropped");
  property p_irq_mask;
    reg_write && reg_addr == VCR_OFS_IRQ_ENABLE && reg_wdata[1:0] == 2'h0 |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
endmodule : vcr_monitor
bind vcr_top vcr_monitor u_mon (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .ref_level_code(ref_level_code), .ref_input_select(ref_input_select),
  .mon_input_select(mon_input_select), .ref_clamp_to_supply(ref_clamp_to_supply),
  .bandgap_enable(bandgap_enable), .result_settled(result_settled),
  .comparator_power_down(comparator_power_down), .irq(irq));
`default_nettype wire

// ==== vcr_top_tb_top.sv ====
// Testbench for the comparator register bank
`timescale 1ns/1ns
`default_nettype none
module vcr_top_tb_top;
  import vcr_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic raw = 1'b0;
  logic above = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] lvl;
  logic [1:0] rsel, msel;
  logic clamp, bg, settled, pd, irq;
  int n_errors = 0;
  int checked = 0;
  vcr_top u_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .compare_result_raw(raw), .ref_above_supply(above), .ref_level_code(lvl),
    .ref_input_select(rsel), .mon_input_select(msel), .ref_clamp_to_supply(clamp),
    .bandgap_enable(bg), .result_settled(settled), .comparator_power_down(pd), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, shared tasks
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  // Read data lives one cycle only, so sample just after the taking edge
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    logic [11:0] ofs [8] = '{12'h0, 12'h4, 12'h8, 12'h200, 12'h204, 12'h208, 12'h20c, 12'h10};
    foreach (ofs[i]) rd(ofs[i], 32'h0, "reset");
    chk("irq", 32'h0, {31'h0, irq});
    $display("reset test done");
  endtask : t_reset
  task automatic t_config;
    wr(VCR_OFS_CONFIG, 32'hffff_ffff);
    rd(VCR_OFS_CONFIG, 32'h000f_0303, "config");
    @(posedge clock);
    above <= 1'b1;
    // Level steps 0x0, 0x5, 0xa, 0xf reach both ends of the code range
    for (int m = 0; m < 4; m++) begin
      wr(VCR_OFS_CONFIG, {12'h0, 4'(m * 5), 6'h0, 2'(m), 6'h0, 2'(m)});
      // Hold each selection past the eight-cycle unsettled window of the checker
      idle(10);
      chk("sel", {23'h0, 4'(m * 5), 2'(m), 2'(m), 1'(m == 1)}, {23'h0, lvl, rsel, msel, bg});
      chk("clamp", {31'h0, 1'(m == 3)}, {31'h0, clamp});
    end
    wr(VCR_OFS_CONFIG, 32'h1);
    idle(20);
    chk("settle", 32'h0, {31'h0, settled});
    idle(1075);
    chk("settle", 32'h0, {31'h0, settled});
    idle(15);
    chk("settle", 32'h1, {31'h0, settled});
    wr(VCR_OFS_CONFIG, 32'h0);
    above <= 1'b0;
    $display("config test done");
  endtask : t_config
  task automatic t_irq;
    @(posedge clock);
    raw <= 1'b1;
    idle(5);
    rd(VCR_OFS_STATUS, 32'h1, "result");
    rd(VCR_OFS_IRQ_STATUS, 32'h0, "unarmed");
    wr(VCR_OFS_IRQ_ENABLE, 32'h2);
    rd(VCR_OFS_IRQ_STATUS, 32'h2, "arm high");
    chk("irq", 32'h1, {31'h0, irq});
    wr(VCR_OFS_IRQ_CLEAR, 32'h0);
    rd(VCR_OFS_IRQ_STATUS, 32'h2, "clear zero");
    wr(VCR_OFS_IRQ_CLEAR, 32'h2);
    rd(VCR_OFS_IRQ_STATUS, 32'h0, "clear");
    wr(VCR_OFS_IRQ_FORCE, 32'h1);
    rd(VCR_OFS_IRQ_STATUS, 32'h1, "force");
    chk("irq", 32'h0, {31'h0, irq});
    wr(VCR_OFS_IRQ_CLEAR, 32'h3);
    @(posedge clock);
    raw <= 1'b0;
    idle(5);
    rd(VCR_OFS_IRQ_STATUS, 32'h0, "masked fall");
    wr(VCR_OFS_IRQ_ENABLE, 32'h3);
    rd(VCR_OFS_IRQ_STATUS, 32'h1, "arm low");
    chk("irq", 32'h1, {31'h0, irq});
    @(posedge clock);
    raw <= 1'b1;
    idle(5);
    rd(VCR_OFS_IRQ_STATUS, 32'h3, "rise");
    wr(VCR_OFS_IRQ_CLEAR, 32'h3);
    @(posedge clock);
    raw <= 1'b0;
    idle(5);
    rd(VCR_OFS_IRQ_STATUS, 32'h1, "fall");
    wr(VCR_OFS_IRQ_ENABLE, 32'h0);
    idle(1);
    chk("irq", 32'h0, {31'h0, irq});
    $display("irq test done");
  endtask : t_irq
  task automatic t_key;
    wr(VCR_OFS_KEY, 32'h36);
    rd(VCR_OFS_KEY, 32'h36, "key");
    chk("pd", 32'h0, {31'h0, pd});
    wr(VCR_OFS_KEY, VCR_SHUTDOWN_KEY);
    rd(VCR_OFS_STATUS, 32'h2, "pwd");
    chk("pd", 32'h1, {31'h0, pd});
    $display("key test done");
  endtask : t_key
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic conclude;
    $display("compares %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    t_reset;
    t_config;
    t_irq;
    t_key;
    conclude;
  end
  // Tests need under 2000 cycles; allow 10000
  initial begin
    #100000;
    n_errors++;
    conclude;
  end
endmodule : vcr_top_tb_top
`default_nettype wire
